// ---- hw/lcd_panel_regs.svh ----
// constants for the lcd panel signal interface: encodings, reset values, timing counts
`ifndef LCD_PANEL_REGS_SVH
`define LCD_PANEL_REGS_SVH

// panel data bus width encodings of bus_width_select
`define BUS_W1            2'h0
`define BUS_W4            2'h1
`define BUS_W8            2'h2

// display mode encodings (bits per pixel in the display buffer)
`define MODE_BW           2'h0
`define MODE_GRAY4        2'h1
`define MODE_GRAY16       2'h2

// reset values of the configuration
`define PANEL_POWER_RST   1'b1
`define CONTRAST_RST      5'h00
`define WIDTH_RST         11'h0a0
`define HEIGHT_RST        10'h078
`define PAGE_WIDTH_RST    10'h014
`define START_ADDR_RST    15'h0000
`define PORT_OUT_RST      8'h00

// field widths
`define BUF_ADDR_W        15
`define WIDTH_W           11
`define HEIGHT_W          10

// line pulse length in link clock cycles
`define LINE_PULSE_CYCLES 3'h2

// ac count value that selects one toggle per frame
`define AC_PER_FRAME      5'h00

`endif

// ---- hw/lcd_panel_pkg.sv ----
// types shared by the lcd panel signal interface
`include "lcd_panel_regs.svh"

package lcd_panel_pkg;

	// line sequencer states, gray coded along gap-prime-active-latch
	typedef enum logic [1:0] {
		ST_PRIME  = 2'b00,
		ST_ACTIVE = 2'b01,
		ST_LATCH  = 2'b11,
		ST_GAP    = 2'b10
	} line_state_e;

	// configuration bundle handed from the system domain to the link domain
	typedef struct packed {
		logic                   panel_power_bit;  // set: panel disconnected
		logic                   display_off_bit;  // set: blank output held low
		logic                   pixel_invert;     // invert panel data
		logic [1:0]             bus_width_select; // 1, 4 or 8 bit bus
		logic [1:0]             display_mode;     // bits per pixel
		logic                   gray_mode_select; // pwm gray line pulse enable
		logic [4:0]             contrast_level;   // pwm contrast pattern
		logic [4:0]             ac_line_count;    // lines per ac toggle, 0 = frame
		logic [`WIDTH_W-1:0]    screen_width;     // pixels per line
		logic [`HEIGHT_W-1:0]   screen_height;    // lines per frame
		logic [9:0]             page_width;       // bytes between line starts
		logic [`BUF_ADDR_W-1:0] start_addr;       // first byte of a frame
		logic [7:0]             port_out_value;   // shared port output values
	} panel_cfg_s;

	// configuration after reset
	localparam panel_cfg_s CFG_RESET = '{
		panel_power_bit:  `PANEL_POWER_RST,
		display_off_bit:  1'b0,
		pixel_invert:     1'b0,
		bus_width_select: `BUS_W1,
		display_mode:     `MODE_BW,
		gray_mode_select: 1'b0,
		contrast_level:   `CONTRAST_RST,
		ac_line_count:    `AC_PER_FRAME,
		screen_width:     `WIDTH_RST,
		screen_height:    `HEIGHT_RST,
		page_width:       `PAGE_WIDTH_RST,
		start_addr:       `START_ADDR_RST,
		port_out_value:   `PORT_OUT_RST
	};

endpackage

// ---- hw/sync_level.sv ----
// two flip-flop synchroniser for level signals
`timescale 1ns/1ns

module sync_level #(
	parameter int W = 1
) (
	input  wire logic         clk,   // destination clock
	input  wire logic         rst_n, // synchronous reset, active low
	input  wire logic [W-1:0] d,     // level from another domain
	output logic      [W-1:0] q      // synchronised level
);

	logic [W-1:0] meta_q; // first stage, read only by the second
	logic [W-1:0] sync_q; // second stage

	// both stages clear in reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= d;
			sync_q <= meta_q;
		end
	end

	assign q = sync_q;

endmodule

// ---- hw/contrast_pwm.sv ----
// contrast pwm generator for the blank output
`timescale 1ns/1ns

module contrast_pwm (
	input  wire logic       clk,     // link clock
	input  wire logic       rst_n,   // link domain reset, active low
	input  wire logic [4:0] level,   // contrast pattern, 0 = maximum
	input  wire logic       blank,   // force output low
	output logic            pwm_out  // pwm contrast output
);

	logic [4:0] cnt_q;  // free running pwm phase
	logic [4:0] cnt_d;
	logic       out_q;  // registered output
	logic       out_d;

	// phase counter and output level
	always_comb begin
		cnt_d = cnt_q + 5'h01;
		if (blank) begin
			out_d = 1'b0;
		end else if (level == 5'h00) begin
			out_d = 1'b1;
		end else begin
			out_d = (cnt_q >= level);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_q <= 5'h00;
			out_q <= 1'b1;
		end else begin
			cnt_q <= cnt_d;
			out_q <= out_d;
		end
	end

	assign pwm_out = out_q;

	a_blank_forces_low: assert property (@(posedge clk) disable iff (!rst_n)
		blank |=> !pwm_out) else $error("blank output not held low");

	a_zero_level_high: assert property (@(posedge clk) disable iff (!rst_n)
		(!blank && level == 5'h00) |=> pwm_out) else $error("zero contrast not steady high");

endmodule

// ---- hw/lcd_panel_signal_interface.sv ----
// lcd panel signal interface: pixel serialiser, panel timing and shared pin control
//
// Behaviour
// - data bus is 1, 4 or 8 bits
// - 1-bit bus uses line 0 only
// - pixel_invert inverts every data bit
// - all panel timing runs on pixel source clock
// - power bit set: shared pins show port values
// - converter output is inverse of power bit
// - contrast pwm from level, zero is maximum
// - display off holds contrast output low
// - zero level keeps contrast output high with display on
// - gray pulse is pwm pulse or line pulse
// - black-white: one bit per pixel, msb left
// - four gray: two bits, top pair left
// - sixteen gray: four bits, upper nibble left
// - programmable size within buffer, virtual page width
// - pixels stream continuously with clock and pulses
// - frame marker after last line until next
// - one line latch pulse per line
// - ac toggles per line count or frame
`timescale 1ns/1ns
`include "lcd_panel_regs.svh"

module lcd_panel_signal_interface (
	input  wire logic                   clk_sys,                // system clock
	input  wire logic                   rst_n,                  // sync reset, active low
	input  wire logic                   lcd_pixel_source_clock, // link clock
	input  wire logic                   panel_power_bit,        // set: panel off
	input  wire logic                   display_off_bit,        // blank the panel
	input  wire logic                   pixel_invert,           // invert data
	input  wire logic [1:0]             bus_width_select,       // bus width
	input  wire logic [1:0]             display_mode,           // bits per pixel
	input  wire logic                   gray_mode_select,       // pwm gray pulse
	input  wire logic [4:0]             contrast_level,         // contrast pattern
	input  wire logic [4:0]             ac_line_count,          // ac period in lines
	input  wire logic [`WIDTH_W-1:0]    screen_width,           // pixels per line
	input  wire logic [`HEIGHT_W-1:0]   screen_height,          // lines per frame
	input  wire logic [9:0]             page_width,             // bytes per line step
	input  wire logic [`BUF_ADDR_W-1:0] start_addr,             // frame start byte
	input  wire logic [7:0]             port_out_value,         // port output values
	output logic      [`BUF_ADDR_W-1:0] buf_rd_addr,            // buffer read address
	input  wire logic [7:0]             buf_rd_data,            // buffer data, 1 cycle
	output logic      [7:0]             port_l_pins,            // shared port pins
	output logic      [3:0]             panel_data_hi,          // data lines 7..4
	output logic                        gray_line_pulse,        // gray line pulse
	output logic                        shift_clock_pulse,      // shift clock
	output logic                        contrast_pwm_out,       // contrast / blank
	output logic                        converter_power_out     // dc-dc converter on
);

	// system domain state
	lcd_panel_pkg::panel_cfg_s cfg_in;    // configuration from the ports
	lcd_panel_pkg::panel_cfg_s hold_q;    // configuration offered to the link
	lcd_panel_pkg::panel_cfg_s hold_d;
	logic                      tog_q;     // request toggle
	logic                      tog_d;
	logic                      conv_q;    // converter power output
	logic                      conv_d;
	logic                      ack_s;     // link acknowledge, synchronised

	// link domain state
	logic                      clk_link;  // panel timing clock
	logic                      link_rst_n; // reset synchronised to the link
	logic                      tog_s;     // request toggle, synchronised
	logic                      ack_q;     // acknowledge toggle
	logic                      ack_d;
	lcd_panel_pkg::panel_cfg_s cfg_q;     // configuration in use by the link
	lcd_panel_pkg::panel_cfg_s cfg_d;
	lcd_panel_pkg::line_state_e state_q;  // line sequencer
	lcd_panel_pkg::line_state_e state_d;
	logic [`WIDTH_W-1:0]       x_q;       // pixel within the line
	logic [`WIDTH_W-1:0]       x_d;
	logic [`HEIGHT_W-1:0]      y_q;       // line within the frame
	logic [`HEIGHT_W-1:0]      y_d;
	logic [`BUF_ADDR_W-1:0]    base_q;    // first byte of this line
	logic [`BUF_ADDR_W-1:0]    base_d;
	logic [`BUF_ADDR_W-1:0]    addr_q;    // next byte to fetch
	logic [`BUF_ADDR_W-1:0]    addr_d;
	logic [7:0]                cur_q;     // byte being serialised
	logic [7:0]                cur_d;
	logic [2:0]                pidx_q;    // pixel within the byte
	logic [2:0]                pidx_d;
	logic                      ph_q;      // pixel phase, one pixel per two cycles
	logic                      ph_d;
	logic [7:0]                gather_q;  // pixels collected for one bus word
	logic [7:0]                gather_d;
	logic [2:0]                gcnt_q;    // pixels in the current word
	logic [2:0]                gcnt_d;
	logic [2:0]                lat_q;     // cycles spent in latch
	logic [2:0]                lat_d;
	logic [3:0]                frame_q;   // frame count for gray modulation
	logic [3:0]                frame_d;
	logic [4:0]                ac_cnt_q;  // lines since last ac toggle
	logic [4:0]                ac_cnt_d;
	logic                      ac_q;      // alternate polarity
	logic                      ac_d;
	logic                      wrap_q;    // last line of a frame just latched
	logic                      wrap_d;
	logic                      fm_q;      // frame marker
	logic                      fm_d;
	logic                      lp_q;      // line latch pulse
	logic                      lp_d;
	logic [7:0]                data_q;    // panel data word
	logic [7:0]                data_d;
	logic                      sck_d;     // shift clock next value

	// pin stage
	logic [7:0]                pins_q;    // shared port pins
	logic [7:0]                pins_d;
	logic [3:0]                hi_q;      // upper data lines
	logic [3:0]                hi_d;
	logic                      gl_q;      // gray line pulse
	logic                      gl_d;
	logic                      sck_q;     // shift clock pin
	logic                      sck_pin_d;

	// pixel extraction helpers
	logic [7:0]                sh_bw;     // byte shifted for one bit pixels
	logic [7:0]                sh_g4;     // byte shifted for two bit pixels
	logic [7:0]                sh_g16;    // byte shifted for four bit pixels
	logic                      lit;       // current pixel is on
	logic [2:0]                w_last;    // last pixel index of a bus word
	logic [2:0]                p_last;    // last pixel index of a byte
	logic                      mid_pulse; // pwm gray pulse at mid line
	logic                      disc;      // panel disconnected

	assign clk_link = lcd_pixel_source_clock;

	// configuration as presented on the ports
	always_comb begin
		cfg_in = '{
			panel_power_bit:  panel_power_bit,
			display_off_bit:  display_off_bit,
			pixel_invert:     pixel_invert,
			bus_width_select: bus_width_select,
			display_mode:     display_mode,
			gray_mode_select: gray_mode_select,
			contrast_level:   contrast_level,
			ac_line_count:    ac_line_count,
			screen_width:     screen_width,
			screen_height:    screen_height,
			page_width:       page_width,
			start_addr:       start_addr,
			port_out_value:   port_out_value
		};
	end

	// system side of the handshake: offer a new word only once the last was taken
	always_comb begin
		hold_d = hold_q;
		tog_d  = tog_q;
		conv_d = ~panel_power_bit;
		if ((cfg_in != hold_q) && (tog_q == ack_s)) begin
			hold_d = cfg_in;
			tog_d  = ~tog_q;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			hold_q <= lcd_panel_pkg::CFG_RESET;
			tog_q  <= 1'b0;
			conv_q <= 1'b0;
		end else begin
			hold_q <= hold_d;
			tog_q  <= tog_d;
			conv_q <= conv_d;
		end
	end

	assign converter_power_out = conv_q;

	// crossings between the two domains
	sync_level #(.W(1)) u_rst_sync (
		.clk   (clk_link),
		.rst_n (1'b1),
		.d     (rst_n),
		.q     (link_rst_n)
	);

	sync_level #(.W(1)) u_tog_sync (
		.clk   (clk_link),
		.rst_n (link_rst_n),
		.d     (tog_q),
		.q     (tog_s)
	);

	sync_level #(.W(1)) u_ack_sync (
		.clk   (clk_sys),
		.rst_n (rst_n),
		.d     (ack_q),
		.q     (ack_s)
	);

	// pixel value from the current byte, leftmost pixel in the top bits
	assign sh_bw  = cur_q << pidx_q;
	assign sh_g4  = cur_q << {pidx_q[1:0], 1'b0};
	assign sh_g16 = cur_q << {pidx_q[0], 2'b00};
	assign disc   = cfg_q.panel_power_bit;
	assign lp_d   = (state_q == lcd_panel_pkg::ST_LATCH) && (lat_q != 3'h0);
	assign mid_pulse = (state_q == lcd_panel_pkg::ST_ACTIVE) && (x_q == (cfg_q.screen_width >> 1));

	// gray levels lit by frame rate modulation against the frame count
	always_comb begin
		case (cfg_q.display_mode)
			`MODE_GRAY4: begin
				lit    = (sh_g4[7:6] > frame_q[1:0]) | (&sh_g4[7:6]);
				p_last = 3'h3;
			end
			`MODE_GRAY16: begin
				lit    = (sh_g16[7:4] > frame_q) | (&sh_g16[7:4]);
				p_last = 3'h1;
			end
			default: begin
				lit    = sh_bw[7];
				p_last = 3'h7;
			end
		endcase
		case (cfg_q.bus_width_select)
			`BUS_W4: w_last = 3'h3;
			`BUS_W8: w_last = 3'h7;
			default: w_last = 3'h0;
		endcase
	end

	// line sequencer: fetch, serialise, latch, advance
	always_comb begin
		cfg_d    = cfg_q;
		ack_d    = ack_q;
		state_d  = state_q;
		x_d      = x_q;
		y_d      = y_q;
		base_d   = base_q;
		addr_d   = addr_q;
		cur_d    = cur_q;
		pidx_d   = pidx_q;
		ph_d     = ph_q;
		gather_d = gather_q;
		gcnt_d   = gcnt_q;
		lat_d    = lat_q;
		frame_d  = frame_q;
		ac_cnt_d = ac_cnt_q;
		ac_d     = ac_q;
		wrap_d   = wrap_q;
		fm_d     = fm_q;
		data_d   = data_q;
		sck_d    = 1'b0;
		// take a new configuration word; it stands still while unacknowledged
		if (tog_s != ack_q) begin
			cfg_d = hold_q;
			ack_d = tog_s;
		end
		case (state_q)
			lcd_panel_pkg::ST_GAP: begin
				// buffer samples the line start address during this cycle
				state_d = lcd_panel_pkg::ST_PRIME;
				if (wrap_q) begin
					fm_d   = 1'b1;
					wrap_d = 1'b0;
				end
			end
			lcd_panel_pkg::ST_PRIME: begin
				cur_d   = buf_rd_data;
				addr_d  = addr_q + 15'h0001;
				pidx_d  = 3'h0;
				ph_d    = 1'b0;
				gcnt_d  = 3'h0;
				x_d     = '0;
				state_d = lcd_panel_pkg::ST_ACTIVE;
			end
			lcd_panel_pkg::ST_ACTIVE: begin
				ph_d = ~ph_q;
				if (ph_q) begin
					gather_d = {gather_q[6:0], lit};
					if (gcnt_q == w_last) begin
						gcnt_d = 3'h0;
						sck_d  = 1'b1;
						case (cfg_q.bus_width_select)
							`BUS_W4: data_d = {4'h0, gather_d[3:0]};
							`BUS_W8: data_d = gather_d;
							default: data_d = {7'h00, lit};
						endcase
						data_d = data_d ^ {8{cfg_q.pixel_invert}};
					end else begin
						gcnt_d = gcnt_q + 3'h1;
					end
					if (pidx_q == p_last) begin
						cur_d  = buf_rd_data;
						addr_d = addr_q + 15'h0001;
						pidx_d = 3'h0;
					end else begin
						pidx_d = pidx_q + 3'h1;
					end
					if (x_q == cfg_q.screen_width - 11'h001) begin
						state_d = lcd_panel_pkg::ST_LATCH;
						lat_d   = 3'h0;
					end else begin
						x_d = x_q + 11'h001;
					end
				end
			end
			default: begin
				lat_d = lat_q + 3'h1;
				if (lat_q == 3'h1) begin
					fm_d = 1'b0;
				end
				if (lat_q == `LINE_PULSE_CYCLES) begin
					state_d = lcd_panel_pkg::ST_GAP;
					if (y_q == cfg_q.screen_height - 10'h001) begin
						y_d     = '0;
						base_d  = cfg_q.start_addr;
						wrap_d  = 1'b1;
						frame_d = frame_q + 4'h1;
					end else begin
						y_d    = y_q + 10'h001;
						base_d = base_q + {5'h00, cfg_q.page_width};
					end
					addr_d = base_d;
					if (cfg_q.ac_line_count == `AC_PER_FRAME) begin
						if (y_q == cfg_q.screen_height - 10'h001) begin
							ac_d = ~ac_q;
						end
					end else if (ac_cnt_q == cfg_q.ac_line_count - 5'h01) begin
						ac_d     = ~ac_q;
						ac_cnt_d = 5'h00;
					end else begin
						ac_cnt_d = ac_cnt_q + 5'h01;
					end
				end
			end
		endcase
		// disconnected panel: park at the start of a frame
		if (disc) begin
			state_d = lcd_panel_pkg::ST_GAP;
			x_d     = '0;
			y_d     = '0;
			base_d  = cfg_q.start_addr;
			addr_d  = cfg_q.start_addr;
			lat_d   = 3'h0;
			wrap_d  = 1'b0;
			fm_d    = 1'b0;
		end
	end

	always_ff @(posedge clk_link) begin
		if (!link_rst_n) begin
			cfg_q    <= lcd_panel_pkg::CFG_RESET;
			ack_q    <= 1'b0;
			state_q  <= lcd_panel_pkg::ST_GAP;
			x_q      <= '0;
			y_q      <= '0;
			base_q   <= `START_ADDR_RST;
			addr_q   <= `START_ADDR_RST;
			cur_q    <= 8'h00;
			pidx_q   <= 3'h0;
			ph_q     <= 1'b0;
			gather_q <= 8'h00;
			gcnt_q   <= 3'h0;
			lat_q    <= 3'h0;
			frame_q  <= 4'h0;
			ac_cnt_q <= 5'h00;
			ac_q     <= 1'b0;
			wrap_q   <= 1'b0;
			fm_q     <= 1'b0;
			lp_q     <= 1'b0;
			data_q   <= 8'h00;
		end else begin
			cfg_q    <= cfg_d;
			ack_q    <= ack_d;
			state_q  <= state_d;
			x_q      <= x_d;
			y_q      <= y_d;
			base_q   <= base_d;
			addr_q   <= addr_d;
			cur_q    <= cur_d;
			pidx_q   <= pidx_d;
			ph_q     <= ph_d;
			gather_q <= gather_d;
			gcnt_q   <= gcnt_d;
			lat_q    <= lat_d;
			frame_q  <= frame_d;
			ac_cnt_q <= ac_cnt_d;
			ac_q     <= ac_d;
			wrap_q   <= wrap_d;
			fm_q     <= fm_d;
			lp_q     <= lp_d;
			data_q   <= data_d;
		end
	end

	assign buf_rd_addr = addr_q;

	// pin stage: lcd signals or port values on the shared pins
	always_comb begin
		if (disc) begin
			pins_d    = cfg_q.port_out_value;
			hi_d      = 4'h0;
			gl_d      = 1'b0;
			sck_pin_d = 1'b0;
		end else begin
			pins_d = {fm_d, lp_d, ac_d, cfg_q.port_out_value[4], data_d[3:0]};
			if (cfg_q.bus_width_select == `BUS_W1) begin
				pins_d[3:1] = cfg_q.port_out_value[3:1];
			end
			hi_d      = (cfg_q.bus_width_select == `BUS_W8) ? data_d[7:4] : 4'h0;
			sck_pin_d = sck_d;
			gl_d      = cfg_q.gray_mode_select ? (lp_d | mid_pulse) : lp_d;
		end
	end

	always_ff @(posedge clk_link) begin
		if (!link_rst_n) begin
			pins_q <= `PORT_OUT_RST;
			hi_q   <= 4'h0;
			gl_q   <= 1'b0;
			sck_q  <= 1'b0;
		end else begin
			pins_q <= pins_d;
			hi_q   <= hi_d;
			gl_q   <= gl_d;
			sck_q  <= sck_pin_d;
		end
	end

	assign port_l_pins       = pins_q;
	assign panel_data_hi     = hi_q;
	assign gray_line_pulse   = gl_q;
	assign shift_clock_pulse = sck_q;

	// contrast and blank output
	contrast_pwm u_contrast (
		.clk     (clk_link),
		.rst_n   (link_rst_n),
		.level   (cfg_q.contrast_level),
		.blank   (cfg_q.display_off_bit),
		.pwm_out (contrast_pwm_out)
	);

	a_conv_follows_power: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$past(rst_n) |-> converter_power_out == !$past(panel_power_bit))
		else $error("converter output not inverse of power bit");

	a_port_takeover: assert property (@(posedge clk_link) disable iff (!link_rst_n)
		cfg_q.panel_power_bit |=> port_l_pins == $past(cfg_q.port_out_value))
		else $error("shared pins not showing port values");

	a_one_bit_gpio: assert property (@(posedge clk_link) disable iff (!link_rst_n)
		(!disc && cfg_q.bus_width_select == `BUS_W1)
		|=> (port_l_pins[3:1] == $past(cfg_q.port_out_value[3:1])) && (panel_data_hi == 4'h0))
		else $error("one bit mode drives extra data lines");

	a_gray_copy_line: assert property (@(posedge clk_link) disable iff (!link_rst_n)
		(!disc && !cfg_q.gray_mode_select) |=> gray_line_pulse == lp_q)
		else $error("gray line pulse differs from line pulse");

	// a disconnect parks the sequencer and may cut a pulse short
	a_line_pulse_width: assert property (@(posedge clk_link)
		disable iff (!link_rst_n || disc) $rose(lp_q) |-> lp_q [*2] ##1 !lp_q)
		else $error("line pulse width wrong");

	a_frame_drop: assert property (@(posedge clk_link) disable iff (!link_rst_n)
		$rose(lp_q) |-> !fm_q)
		else $error("frame marker still high at line pulse");

	a_sck_single: assert property (@(posedge clk_link) disable iff (!link_rst_n)
		shift_clock_pulse |=> !shift_clock_pulse)
		else $error("shift clock high two cycles");

	a_ac_per_frame: assert property (@(posedge clk_link) disable iff (!link_rst_n)
		(!disc && cfg_q.ac_line_count == `AC_PER_FRAME && $changed(ac_q)) |=> fm_q)
		else $error("ac toggled away from frame end");

	a_invert_word: assert property (@(posedge clk_link) disable iff (!link_rst_n)
		(sck_d && cfg_q.bus_width_select == `BUS_W8)
		|=> data_q == ($past(gather_d) ^ {8{$past(cfg_q.pixel_invert)}}))
		else $error("panel data word not inverted as set");

endmodule

// ---- verification/panel_model.sv ----
// panel driver model: samples data on the falling shift clock, counts lines per frame
`timescale 1ns/1ns
module panel_model (
	input  wire logic       shift_clock_pulse, // shift clock from the block
	input  wire logic [7:0] port_l_pins,       // marker, line pulse, ac, low data
	input  wire logic [3:0] panel_data_hi,     // data lines 7..4
	output logic      [7:0] line_word,         // serial bits of the last line
	output logic      [7:0] last_word,         // last parallel word taken
	output logic      [9:0] per_frame          // line pulses in the last frame
);
	logic [7:0] sr;    // shift of data line 0
	logic [9:0] lines; // line pulses since the frame marker
	// segment drivers take data on the falling shift clock
	always @(negedge shift_clock_pulse) begin
		sr <= {sr[6:0], port_l_pins[0]};
		last_word <= {panel_data_hi, port_l_pins[3:0]};
	end
	// line pulse latches the line, frame marker closes the count
	always @(posedge port_l_pins[6] or posedge port_l_pins[7]) begin
		if (port_l_pins[6]) begin
			line_word <= sr;
			lines <= lines + 10'h001;
		end else begin
			per_frame <= lines;
			lines <= 10'h000;
		end
	end
endmodule

// ---- verification/lcd_panel_signal_interface_bench.sv ----
// self-checking bench for the lcd panel signal interface
`timescale 1ns/1ns
module lcd_panel_signal_interface_bench;
	logic        clk_sys, rst_n, lck, ppb, doff, inv, gms, glp, sck, pwm, conv; // controls
	logic [1:0]  bws, dmode;          // bus width and display mode
	logic [4:0]  clev, acl;           // contrast and ac count
	logic [10:0] wid;                 // pixels per line
	logic [9:0]  hgt, pgw, per_frame; // size and line count
	logic [14:0] sta, rda;            // start and read address
	logic [7:0]  pov, rdd, pl, line_word, last_word, pat; // port, data and buffer pattern
	logic [3:0]  hi;                  // data lines 7..4
	int          err_total, compares, cycles, n, m; // counters
	lcd_panel_signal_interface i_lcd_panel_signal_interface (.clk_sys(clk_sys), .rst_n(rst_n),
		.lcd_pixel_source_clock(lck), .panel_power_bit(ppb), .display_off_bit(doff),
		.pixel_invert(inv), .bus_width_select(bws), .display_mode(dmode),
		.gray_mode_select(gms), .contrast_level(clev), .ac_line_count(acl),
		.screen_width(wid), .screen_height(hgt), .page_width(pgw), .start_addr(sta),
		.port_out_value(pov), .buf_rd_addr(rda), .buf_rd_data(rdd), .port_l_pins(pl),
		.panel_data_hi(hi), .gray_line_pulse(glp), .shift_clock_pulse(sck),
		.contrast_pwm_out(pwm), .converter_power_out(conv));
	panel_model i_panel_model (.shift_clock_pulse(sck), .port_l_pins(pl), .panel_data_hi(hi),
		.line_word(line_word), .last_word(last_word), .per_frame(per_frame));
	// clocks: system 40 ns, link 30 ns with its own phase
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	initial begin
		lck = 1'b0;
		#7;
		forever #15 lck = ~lck;
	end
	// display buffer holds one pattern, read one link edge late
	always @(posedge lck) rdd <= pat;
	// hang guard
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			close_out();
		end
	end
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys);
	endtask
	// reset state: panel off, port values shown, contrast steady high
	task automatic t_reset();
		tick(5);
		check("conv", conv, 1'b0);
		check("pins", pl, 8'h3c);
		check("pwm", pwm, 1'b1);
	endtask
	// 1-bit streaming, shared pins, frame count, inversion
	task automatic t_stream();
		ppb <= 1'b0;
		pov <= 8'h0e;
		tick(2);
		check("conv", conv, 1'b1);
		tick(150);
		check("line", line_word, 8'ha5);
		check("gpio", pl[3:1], 3'h7);
		check("frame", per_frame, hgt);
		inv <= 1'b1;
		tick(150);
		check("inv", line_word, 8'h5a);
	endtask
	// wider buses put the first pixel in the top used line
	task automatic t_wide();
		inv <= 1'b0;
		bws <= 2'h2;
		tick(150);
		check("w8", last_word, 8'ha5);
		bws <= 2'h1;
		tick(150);
		check("w4", last_word, 8'h05);
	endtask
	// gray pulse copies the line pulse, pwm gray adds a mid-line pulse; gray pixel maps
	task automatic t_gray();
		logic ac_seen;
		repeat (40) begin
			tick(1);
			check("lp2", glp, pl[6]);
		end
		gms <= 1'b1;
		tick(20);
		{n, m} = '0;
		@(negedge lck);
		ac_seen = pl[5];
		repeat (42) begin
			@(negedge lck);
			if (glp === 1'b1) n++;
			if (pl[5] !== ac_seen) m++;
			ac_seen = pl[5];
		end
		check("lp2 pwm", n, 8);
		check("ac flips", m, 1);
		tick(1);
		bws <= 2'h0;
		dmode <= 2'h1;
		pat <= 8'hf0;
		tick(150);
		check("gray4", line_word, 8'hcc);
		dmode <= 2'h2;
		tick(150);
		check("gray16", line_word, 8'haa);
	endtask
	// contrast duty over two pwm periods, then blanking
	task automatic t_pwm(input logic off, input int exp);
		tick(1);
		doff <= off;
		clev <= 5'h10;
		tick(20);
		n = 0;
		repeat (64) begin
			@(negedge lck);
			if (pwm === 1'b1) n++;
		end
		check("duty", n, exp);
	endtask
	// power bit set again hands the pins back to port values
	task automatic t_off();
		tick(1);
		ppb <= 1'b1;
		tick(20);
		check("pins", pl, 8'h0e);
		check("hi", hi, 4'h0);
		check("conv", conv, 1'b0);
		pov <= 8'h00;
		sta <= 15'h0123;
		tick(20);
		check("pins zero", pl, 8'h00);
		check("park addr", rda, 15'h0123);
	endtask
	task automatic close_out();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// main sequence
	initial begin
		{rst_n, doff, inv, gms, bws, dmode, clev, acl} = '0;
		{err_total, compares, cycles} = '0;
		ppb = 1'b1;
		wid = 11'h010;
		hgt = 10'h002;
		pgw = 10'h001;
		sta = 15'h0000;
		pov = 8'h3c;
		pat = 8'ha5;
		tick(4);
		rst_n <= 1'b1;
		wid <= 11'h008;
		t_reset();
		t_stream();
		t_wide();
		t_gray();
		t_pwm(1'b0, 32);
		t_pwm(1'b1, 0);
		t_off();
		close_out();
	end
endmodule
